// ==== tsl_defines.svh ====
// Constants for the task pointer loader: register offsets, fields, block layout, reset values
// What this block does
// R01 - Legacy mode ignores the upper 32 base bits of the task block descriptor.
// R02 - In 64-bit mode the descriptor is 16 bytes, giving a 64-bit base.
// R03 - Upper base bits are fetched only by a pointer load in 64-bit mode.
// R04 - Compatibility mode reads an 8-byte descriptor; long mode needs the 64-bit block type.
// R05 - Compatibility and 64-bit modes use the full 64-bit base of the pointer register.
// R06 - Static block fields are read on a switch, never written back on suspend.
// R07 - Dynamic block fields are read on a switch and written back on suspend.
// R08 - Only the first 104 bytes of the task block are touched.
// R09 - A pointer load reads or writes no task block field.
// R10 - A pointer load fills the register and marks busy, without switching tasks.
// R11 - Bytes 01h-00h hold the previous task selector, a dynamic field.
// R12 - Bytes 1Bh-04h hold three static stack selector and offset pairs.
// R13 - Bytes 1Fh-1Ch hold the static page table base, loaded for the new task.
// R14 - Bytes 23h-20h hold the dynamic resume instruction pointer.
// R15 - Bytes 27h-24h hold the dynamic flags image taken at suspend.
// R16 - Bytes 47h-28h hold eight dynamic general registers in fixed order.
// R17 - Bytes 5Fh-48h hold six dynamic segment selectors, each in a low half.
// R18 - Bytes 63h-60h hold the static local table selector.
// R19 - Trap bit 0 of byte 64h in the new block raises a debug exception.
// R20 - Bytes 67h-66h hold the static 16-bit offset of the permission map.
// R21 - Software places the permission map above byte 103, within 64 Kbytes.
// R22 - Software fills the last permission map byte with all ones.
// R23 - A descriptor limit below 67h raises the invalid block fault on a switch.
// R24 - Descriptor bit 9 is busy; a transfer to a busy task raises protection fault.
// R25 - The pointer register has a visible selector and a hidden fetched descriptor.
// R26 - Loading an available 64-bit block sets busy, which is never cleared.
// R27 - A switch writes all outgoing dynamic fields before reading the incoming block.
`ifndef TSL_DEFINES_SVH
`define TSL_DEFINES_SVH

`define TSL_OFS_CTRL 12'h000
`define TSL_OFS_SEL 12'h004
`define TSL_OFS_GDT_LO 12'h008
`define TSL_OFS_GDT_HI 12'h00c
`define TSL_OFS_STATUS 12'h010
`define TSL_OFS_TR_SEL 12'h014
`define TSL_OFS_TR_BASE_LO 12'h018
`define TSL_OFS_TR_BASE_HI 12'h01c
`define TSL_OFS_TR_LIMIT 12'h020
`define TSL_OFS_TR_ATTR 12'h024
`define TSL_OFS_BLOCK 12'h100

`define TSL_CTRL_LOAD_BIT 0
`define TSL_CTRL_SWITCH_BIT 1
`define TSL_STAT_BUSY_BIT 0
`define TSL_STAT_DONE_BIT 1
`define TSL_STAT_TS_BIT 2
`define TSL_STAT_GP_BIT 3
`define TSL_STAT_DB_BIT 4

`define TSL_BLOCK_WORDS 26
`define TSL_W_LINK 5'd0
`define TSL_W_PTB 5'd7
`define TSL_W_IP 5'd8
`define TSL_W_FLAGS 5'd9
`define TSL_W_SEG_LAST 5'd23
`define TSL_W_LDT 5'd24
`define TSL_W_TRAP 5'd25
`define TSL_W_LAST 5'd25
`define TSL_TRAP_BIT 0
`define TSL_IOMAP_LSB 16

`define TSL_D_TYPE_LSB 8
`define TSL_D_BUSY_BIT 9
`define TSL_D_S_BIT 12
`define TSL_D_P_BIT 15
`define TSL_D_G_BIT 23
`define TSL_D_TYPE_MASK 4'hd
`define TSL_D_TYPE_TSS 4'h9
`define TSL_MIN_LIMIT 32'h0000_0067
`define TSL_SEL_TI_BIT 2

`define TSL_RST_WORD 32'h0000_0000
`define TSL_RST_BASE 64'h0000_0000_0000_0000

`endif

// ==== tsl_pkg.sv ====
// Types shared by the task pointer loader files
package tsl_pkg;
	typedef enum logic [1:0] {
		TSL_MODE_LEGACY = 2'b00,
		TSL_MODE_COMPAT = 2'b01,
		TSL_MODE_LM64 = 2'b10
	} tsl_mode_t;

	typedef enum logic [2:0] {
		TSL_S_IDLE = 3'b000,
		TSL_S_DESC = 3'b001,
		TSL_S_CHECK = 3'b010,
		TSL_S_SAVE = 3'b011,
		TSL_S_LOAD = 3'b100,
		TSL_S_MARK = 3'b101
	} tsl_state_t;
endpackage

// ==== tsl_desc_if.sv ====
// Descriptor words in, decoded fields out
`timescale 1ns/1ns
interface tsl_desc_if;
	logic [31:0] w0;
	logic [31:0] w1;
	logic [31:0] w2;
	tsl_pkg::tsl_mode_t mode;
	logic [63:0] base;
	logic [31:0] limit;
	logic busy;
	logic type_ok;
	logic limit_ok;
	modport dec (input w0, w1, w2, mode, output base, limit, busy, type_ok, limit_ok);
	modport eng (output w0, w1, w2, mode, input base, limit, busy, type_ok, limit_ok);
endinterface

// ==== tsl_desc_dec.sv ====
// Decoder of a task block descriptor
`timescale 1ns/1ns
`include "tsl_defines.svh"
module tsl_desc_dec (
	// Descriptor carrier
	tsl_desc_if.dec dp
);
	import tsl_pkg::*;

	logic [19:0] raw_limit;
	logic [3:0] dtype;

	always_comb begin
		raw_limit = {dp.w1[19:16], dp.w0[15:0]};
		dtype = dp.w1[`TSL_D_TYPE_LSB +: 4];
		// R01 R04 narrow descriptor base
		dp.base[31:0] = {dp.w1[31:24], dp.w1[7:0], dp.w0[31:16]};
		// R02 R03 upper base from 64-bit only
		dp.base[63:32] = (dp.mode == TSL_MODE_LM64) ? dp.w2 : 32'h0000_0000;
		dp.limit = dp.w1[`TSL_D_G_BIT] ? {raw_limit, 12'hfff} : {12'h000, raw_limit};
		// R24 busy flag
		dp.busy = dp.w1[`TSL_D_BUSY_BIT];
		dp.type_ok = dp.w1[`TSL_D_P_BIT] & ~dp.w1[`TSL_D_S_BIT] & ((dtype & `TSL_D_TYPE_MASK) == `TSL_D_TYPE_TSS);
		// R23 least limit
		dp.limit_ok = dp.limit >= `TSL_MIN_LIMIT;
	end
endmodule

// ==== tsl_loader.sv ====
// Task pointer register loader and task block save and restore engine
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`include "tsl_defines.svh"
module tsl_loader (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Core operating mode
	input wire tsl_pkg::tsl_mode_t cpu_mode,
	// System memory master
	output logic mem_req,
	output logic mem_we,
	output logic [63:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	// Exceptions
	output logic debug_exception,
	output logic invalid_task_block_fault,
	output logic general_protection_fault
);
	import tsl_pkg::*;

	tsl_desc_if dif();

	tsl_desc_dec u_dec (
		.dp(dif.dec)
	);

	// Bus pipeline
	logic ap_wr, next_ap_wr;
	logic ap_rd, next_ap_rd;
	logic rd_wait, next_rd_wait;
	logic [11:0] ap_addr, next_ap_addr;
	logic [31:0] next_hrdata;
	logic [31:0] rd_mux;
	logic xfer;

	// Registers and engine
	logic [63:0] gdt_base, next_gdt_base;
	logic [15:0] sel_req, next_sel_req;
	logic [15:0] tgt_sel, next_tgt_sel;
	logic [15:0] tr_sel, next_tr_sel;
	logic [63:0] tr_base, next_tr_base;
	logic [31:0] tr_limit, next_tr_limit;
	logic [31:0] tr_attr, next_tr_attr;
	logic tr_valid, next_tr_valid;
	logic [4:1] stat, next_stat;
	logic [31:0] blk [0:`TSL_BLOCK_WORDS-1];
	logic [31:0] next_blk [0:`TSL_BLOCK_WORDS-1];
	tsl_state_t st, next_st;
	logic is_sw, next_is_sw;
	logic [4:0] cnt, next_cnt;
	logic [31:0] w0, next_w0;
	logic [31:0] w1, next_w1;
	logic [31:0] w2, next_w2;
	logic next_mem_req, next_mem_we;
	logic [63:0] next_mem_addr;
	logic [31:0] next_mem_wdata;
	logic next_db, next_ts, next_gp, next_done;
	logic wr_hit;
	logic go_load, go_switch;
	logic [4:0] desc_last;
	logic [63:0] gdt_eff;
	logic [63:0] desc_addr;
	logic [63:0] old_base;
	logic [31:0] busy_w1;
	logic [4:0] blk_idx;

	function automatic logic is_dyn(input logic [4:0] idx);
		// R07 R11 R14 R15 R16 R17 dynamic words
		is_dyn = (idx == `TSL_W_LINK) | ((idx >= `TSL_W_IP) & (idx <= `TSL_W_SEG_LAST));
	endfunction

	assign dif.w0 = w0;
	assign dif.w1 = w1;
	assign dif.w2 = w2;
	assign dif.mode = cpu_mode;

	assign xfer = hsel & htrans[1] & hready;
	assign hreadyout = ~(ap_rd & ~rd_wait);
	assign hresp = 1'b0;

	always_comb begin
		blk_idx = ap_addr[6:2];
		rd_mux = 32'h0000_0000;
		unique case (ap_addr)
			`TSL_OFS_SEL: rd_mux = {16'h0000, sel_req};
			`TSL_OFS_GDT_LO: rd_mux = gdt_base[31:0];
			`TSL_OFS_GDT_HI: rd_mux = gdt_base[63:32];
			`TSL_OFS_STATUS: rd_mux = {27'h0, stat, st != TSL_S_IDLE};
			`TSL_OFS_TR_SEL: rd_mux = {16'h0000, tr_sel};
			`TSL_OFS_TR_BASE_LO: rd_mux = tr_base[31:0];
			`TSL_OFS_TR_BASE_HI: rd_mux = tr_base[63:32];
			`TSL_OFS_TR_LIMIT: rd_mux = tr_limit;
			`TSL_OFS_TR_ATTR: rd_mux = tr_attr;
			default: begin
				if (ap_addr[11:7] == `TSL_OFS_BLOCK >> 7 && blk_idx <= `TSL_W_LAST) begin
					rd_mux = blk[blk_idx];
				end
			end
		endcase
	end

	always_comb begin
		next_ap_wr = hready ? (xfer & hwrite) : ap_wr;
		next_ap_rd = hready ? (xfer & ~hwrite) : ap_rd;
		next_ap_addr = xfer ? haddr[11:0] : ap_addr;
		next_rd_wait = ap_rd & ~rd_wait;
		next_hrdata = (ap_rd & ~rd_wait) ? rd_mux : hrdata;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr <= 1'b0;
			ap_rd <= 1'b0;
			rd_wait <= 1'b0;
			ap_addr <= 12'h000;
			hrdata <= `TSL_RST_WORD;
		end else begin
			ap_wr <= next_ap_wr;
			ap_rd <= next_ap_rd;
			rd_wait <= next_rd_wait;
			ap_addr <= next_ap_addr;
			hrdata <= next_hrdata;
		end
	end

	always_comb begin
		wr_hit = ap_wr & (ap_addr == `TSL_OFS_CTRL);
		go_load = wr_hit & hwdata[`TSL_CTRL_LOAD_BIT];
		go_switch = wr_hit & hwdata[`TSL_CTRL_SWITCH_BIT];
		// R02 R04 descriptor length by mode
		desc_last = (cpu_mode == TSL_MODE_LM64) ? 5'd3 : 5'd1;
		// R01 legacy table base
		gdt_eff = (cpu_mode == TSL_MODE_LEGACY) ? {32'h0000_0000, gdt_base[31:0]} : gdt_base;
		desc_addr = gdt_eff + {48'h0000_0000_0000, tgt_sel[15:3], 3'b000} + {59'h0, cnt[2:0], 2'b00};
		// R01 R05 base width by mode
		old_base = (cpu_mode == TSL_MODE_LEGACY) ? {32'h0000_0000, tr_base[31:0]} : tr_base;
		busy_w1 = w1 | (32'h1 << `TSL_D_BUSY_BIT);

		next_gdt_base = gdt_base;
		next_sel_req = sel_req;
		next_tgt_sel = tgt_sel;
		next_tr_sel = tr_sel;
		next_tr_base = tr_base;
		next_tr_limit = tr_limit;
		next_tr_attr = tr_attr;
		next_tr_valid = tr_valid;
		next_st = st;
		next_is_sw = is_sw;
		next_cnt = cnt;
		next_w0 = w0;
		next_w1 = w1;
		next_w2 = w2;
		next_mem_req = mem_req;
		next_mem_we = mem_we;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_db = 1'b0;
		next_ts = 1'b0;
		next_gp = 1'b0;
		next_done = 1'b0;
		for (int i = 0; i < `TSL_BLOCK_WORDS; i++) begin
			next_blk[i] = blk[i];
		end

		if (ap_wr) begin
			unique case (ap_addr)
				`TSL_OFS_SEL: next_sel_req = hwdata[15:0];
				`TSL_OFS_GDT_LO: next_gdt_base[31:0] = hwdata;
				`TSL_OFS_GDT_HI: next_gdt_base[63:32] = hwdata;
				default: begin
					if (st == TSL_S_IDLE && ap_addr[11:7] == `TSL_OFS_BLOCK >> 7 && blk_idx <= `TSL_W_LAST) begin
						next_blk[blk_idx] = hwdata;
					end
				end
			endcase
		end

		unique case (st)
			TSL_S_IDLE: begin
				if (go_load | go_switch) begin
					next_is_sw = ~go_load;
					next_tgt_sel = sel_req;
					next_cnt = 5'd0;
					if (~go_load & (cpu_mode != TSL_MODE_LEGACY)) begin
						next_gp = 1'b1;
					end else if (sel_req[`TSL_SEL_TI_BIT]) begin
						next_gp = 1'b1;
					end else begin
						next_st = TSL_S_DESC;
					end
				end
			end
			TSL_S_DESC: begin
				// R25 fetch hidden descriptor part
				if (!mem_req) begin
					next_mem_req = 1'b1;
					next_mem_we = 1'b0;
					next_mem_addr = desc_addr;
				end else if (mem_ack) begin
					next_mem_req = 1'b0;
					unique case (cnt[1:0])
						2'd0: next_w0 = mem_rdata;
						2'd1: next_w1 = mem_rdata;
						2'd2: next_w2 = mem_rdata;
						2'd3: next_w2 = w2;
					endcase
					if (cnt == desc_last) begin
						next_st = TSL_S_CHECK;
					end else begin
						next_cnt = cnt + 5'd1;
					end
				end
			end
			TSL_S_CHECK: begin
				next_cnt = 5'd0;
				next_st = TSL_S_IDLE;
				if (cnt == 5'd1) begin
					next_w2 = 32'h0000_0000;
				end
				if (!dif.type_ok) begin
					next_gp = 1'b1;
				// R24 busy target refused
				end else if (dif.busy) begin
					next_gp = 1'b1;
				// R23 short limit on switch
				end else if (is_sw & ~dif.limit_ok) begin
					next_ts = 1'b1;
				// R09 R10 load skips block access
				end else if (!is_sw) begin
					next_cnt = 5'd1;
					next_st = TSL_S_MARK;
				// R27 save before load
				end else if (tr_valid) begin
					next_st = TSL_S_SAVE;
				end else begin
					next_st = TSL_S_LOAD;
				end
			end
			TSL_S_SAVE: begin
				// R06 R07 only dynamic words written
				if (!is_dyn(cnt)) begin
					next_cnt = cnt + 5'd1;
				end else if (!mem_req) begin
					next_mem_req = 1'b1;
					next_mem_we = 1'b1;
					next_mem_addr = old_base + {57'h0, cnt, 2'b00};
					next_mem_wdata = blk[cnt];
				end else if (mem_ack) begin
					next_mem_req = 1'b0;
					next_mem_we = 1'b0;
					next_cnt = cnt + 5'd1;
				end
				if (cnt == `TSL_W_LAST) begin
					next_cnt = 5'd0;
					next_st = TSL_S_LOAD;
				end
			end
			TSL_S_LOAD: begin
				// R06 R08 R12 R13 R18 R20 read all 104 bytes
				if (!mem_req) begin
					next_mem_req = 1'b1;
					next_mem_we = 1'b0;
					next_mem_addr = dif.base + {57'h0, cnt, 2'b00};
				end else if (mem_ack) begin
					next_mem_req = 1'b0;
					next_blk[cnt] = mem_rdata;
					if (cnt == `TSL_W_LAST) begin
						next_cnt = 5'd1;
						next_st = TSL_S_MARK;
					end else begin
						next_cnt = cnt + 5'd1;
					end
				end
			end
			TSL_S_MARK: begin
				next_cnt = 5'd1;
				// R10 R24 R26 set busy in descriptor
				if (!mem_req) begin
					next_mem_req = 1'b1;
					next_mem_we = 1'b1;
					next_mem_addr = desc_addr;
					next_mem_wdata = busy_w1;
				end else if (mem_ack) begin
					next_mem_req = 1'b0;
					next_mem_we = 1'b0;
					// R05 R25 full base kept in register
					next_tr_sel = tgt_sel;
					next_tr_base = dif.base;
					next_tr_limit = dif.limit;
					next_tr_attr = busy_w1;
					next_tr_valid = 1'b1;
					next_done = 1'b1;
					// R19 trap bit of new block
					next_db = is_sw & blk[`TSL_W_TRAP][`TSL_TRAP_BIT];
					next_st = TSL_S_IDLE;
				end
			end
			default: begin
				next_st = TSL_S_IDLE;
				next_mem_req = 1'b0;
			end
		endcase

		next_stat = stat;
		if (ap_wr && ap_addr == `TSL_OFS_STATUS) begin
			next_stat = stat & ~hwdata[4:1];
		end
		next_stat = next_stat | {next_db, next_gp, next_ts, next_done};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gdt_base <= `TSL_RST_BASE;
			sel_req <= 16'h0000;
			tgt_sel <= 16'h0000;
			tr_sel <= 16'h0000;
			tr_base <= `TSL_RST_BASE;
			tr_limit <= `TSL_RST_WORD;
			tr_attr <= `TSL_RST_WORD;
			tr_valid <= 1'b0;
			stat <= 4'h0;
			st <= TSL_S_IDLE;
			is_sw <= 1'b0;
			cnt <= 5'd0;
			w0 <= `TSL_RST_WORD;
			w1 <= `TSL_RST_WORD;
			w2 <= `TSL_RST_WORD;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= `TSL_RST_BASE;
			mem_wdata <= `TSL_RST_WORD;
			debug_exception <= 1'b0;
			invalid_task_block_fault <= 1'b0;
			general_protection_fault <= 1'b0;
			for (int i = 0; i < `TSL_BLOCK_WORDS; i++) begin
				blk[i] <= `TSL_RST_WORD;
			end
		end else begin
			gdt_base <= next_gdt_base;
			sel_req <= next_sel_req;
			tgt_sel <= next_tgt_sel;
			tr_sel <= next_tr_sel;
			tr_base <= next_tr_base;
			tr_limit <= next_tr_limit;
			tr_attr <= next_tr_attr;
			tr_valid <= next_tr_valid;
			stat <= next_stat;
			st <= next_st;
			is_sw <= next_is_sw;
			cnt <= next_cnt;
			w0 <= next_w0;
			w1 <= next_w1;
			w2 <= next_w2;
			mem_req <= next_mem_req;
			mem_we <= next_mem_we;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			debug_exception <= next_db;
			invalid_task_block_fault <= next_ts;
			general_protection_fault <= next_gp;
			for (int i = 0; i < `TSL_BLOCK_WORDS; i++) begin
				blk[i] <= next_blk[i];
			end
		end
	end
endmodule

// ==== tsl_mem_model.sv ====
// System memory model on the far side of the loader's memory port
`timescale 1ns/1ns
module tsl_mem_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [63:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ack,
	// Answer delay in cycles
	input wire logic [1:0] lag
);
	logic [31:0] mem [logic [63:0]];
	int n_rd = 0;
	int n_wr = 0;
	logic [1:0] wait_cnt;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
			wait_cnt <= 2'h0;
		end else begin
			mem_ack <= 1'b0;
			// Stale read data is scrambled, never held
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack && wait_cnt < lag) begin
				wait_cnt <= wait_cnt + 2'h1;
			end else if (mem_req && !mem_ack) begin
				wait_cnt <= 2'h0;
				mem_ack <= 1'b1;
				if (mem_we) begin
					mem[mem_addr] = mem_wdata;
					n_wr++;
				end else begin
					mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
					n_rd++;
				end
			end
		end
	end
endmodule

// ==== tsl_loader_chk.sv ====
// Port checker for the task pointer loader
`timescale 1ns/1ns
module tsl_loader_chk (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	// Mode and memory
	input wire tsl_pkg::tsl_mode_t cpu_mode,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [63:0] mem_addr,
	input wire logic mem_ack,
	// Exceptions
	input wire logic debug_exception,
	input wire logic invalid_task_block_fault,
	input wire logic general_protection_fault
);
	import tsl_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire go = hsel && htrans[1] && hready;
	property p_rd_wait; go && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	property p_wr_ready; go && hwrite |=> hreadyout; endproperty
	a_wr_ready: assert property (p_wr_ready) else $error("write stalled");
	property p_rd_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_req_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we); endproperty
	a_req_hold: assert property (p_req_hold) else $error("request not held");
	property p_req_gap; mem_req && mem_ack |=> !mem_req; endproperty
	a_req_gap: assert property (p_req_gap) else $error("no gap after ack");
	property p_legacy_hi; cpu_mode == TSL_MODE_LEGACY && mem_req |-> mem_addr[63:32] == 32'h0; endproperty
	a_legacy_hi: assert property (p_legacy_hi) else $error("high address in legacy");
	property p_gp; general_protection_fault |-> !mem_req ##1 !general_protection_fault; endproperty
	a_gp: assert property (p_gp) else $error("protection pulse wrong");
	property p_ts; invalid_task_block_fault |=> !invalid_task_block_fault && !mem_req; endproperty
	a_ts: assert property (p_ts) else $error("block fault pulse wrong");
	property p_db; debug_exception |-> !invalid_task_block_fault ##1 !debug_exception; endproperty
	a_db: assert property (p_db) else $error("debug pulse wrong");
	c_wr: cover property (mem_req && mem_we && mem_ack);
	c_gp: cover property (general_protection_fault);
	c_db: cover property (debug_exception);
endmodule
bind tsl_loader tsl_loader_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .cpu_mode(cpu_mode),
	.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_ack(mem_ack),
	.debug_exception(debug_exception), .invalid_task_block_fault(invalid_task_block_fault),
	.general_protection_fault(general_protection_fault));

// ==== tb.sv ====
// Self-checking bench for the task pointer loader
`timescale 1ns/1ns
`include "tsl_defines.svh"
module tb;
	import tsl_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, mem_req, mem_we, mem_ack;
	tsl_mode_t cpu_mode = TSL_MODE_LEGACY;
	logic [63:0] mem_addr, b;
	logic [31:0] hrdata, mem_wdata, mem_rdata, st, rd, dyn [26], blk [26];
	logic [1:0] lag = 2'h0;
	int err_count = 0;
	int n_compared = 0;
	int r0, w0;
	logic hresp, exc_db, exc_ts, exc_gp;
	int n_db = 0;
	int n_ts = 0;
	int n_gp = 0;
	int d0, t0, g0;
	tsl_loader u_tsl_loader (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .cpu_mode(cpu_mode), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
		.debug_exception(exc_db), .invalid_task_block_fault(exc_ts), .general_protection_fault(exc_gp));
	tsl_mem_model u_tsl_mem_model (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .lag(lag));
	initial begin
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (exc_db === 1'b1) begin
			n_db++;
		end
		if (exc_ts === 1'b1) begin
			n_ts++;
		end
		if (exc_gp === 1'b1) begin
			n_gp++;
		end
	end
	initial begin
		#400000;
		err_count++;
		print_verdict();
	end
	task automatic print_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
		logic ok;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		for (int ph = 0; ph < 2; ph++) begin
			ok = 1'b0;
			while (!ok) begin
				@(negedge hclk);
				ok = (hreadyout === 1'b1);
				rd = hrdata;
				@(posedge hclk);
			end
			if (ph == 0) begin
				htrans <= 2'h0;
				hwdata <= wd;
			end
		end
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk({31'h0, hresp, rd}, {32'h0, exp});
	endtask
	task automatic op(input tsl_mode_t m, input logic [63:0] global_descriptor_table, input logic [15:0] sel, input logic [31:0] ctl);
		cpu_mode <= m;
		lag <= 2'($urandom % 4);
		r0 = u_tsl_mem_model.n_rd;
		w0 = u_tsl_mem_model.n_wr;
		d0 = n_db;
		t0 = n_ts;
		g0 = n_gp;
		bus(1'b1, `TSL_OFS_GDT_LO, global_descriptor_table[31:0]);
		bus(1'b1, `TSL_OFS_GDT_HI, global_descriptor_table[63:32]);
		bus(1'b1, `TSL_OFS_SEL, {16'h0, sel});
		bus(1'b1, `TSL_OFS_CTRL, ctl);
		for (int i = 0; i < 200; i++) begin
			bus(1'b0, `TSL_OFS_STATUS, 32'h0);
			if (rd[3:1] != 3'h0) break;
		end
		st = rd;
		chk(64'(n_db - d0), 64'(st[4]));
		chk(64'(n_gp - g0), 64'(st[3]));
		chk(64'(n_ts - t0), 64'(st[2]));
		bus(1'b1, `TSL_OFS_STATUS, 32'h1e);
	endtask
	task automatic put_desc(input logic [63:0] at, input logic [63:0] bs, input logic [19:0] l);
		u_tsl_mem_model.mem[at] = {bs[15:0], l[15:0]};
		u_tsl_mem_model.mem[at + 4] = {bs[31:24], 4'h0, l[19:16], 8'h89, bs[23:16]};
		u_tsl_mem_model.mem[at + 8] = bs[63:32];
		u_tsl_mem_model.mem[at + 12] = 32'h0;
	endtask
	function automatic logic isdyn(input int i);
		return i == 0 || (i >= 8 && i <= 23);
	endfunction
	initial begin
		void'($urandom(27));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b1, 12'h0f0, 32'hffff_ffff);
		rchk(12'h0f0, 32'h0);
		rchk(`TSL_OFS_STATUS, 32'h0);
		// Legacy load with a high table base that is dropped
		put_desc(64'h1010, 64'hffff_0000_0000_2000, 20'h00067);
		op(TSL_MODE_LEGACY, 64'h7_0000_1000, 16'h0010, 32'h1);
		chk(st, 32'h2);
		chk(64'(u_tsl_mem_model.n_rd - r0), 64'h2);
		chk(64'(u_tsl_mem_model.n_wr - w0), 64'h1);
		chk(u_tsl_mem_model.mem[64'h1014], 32'h0000_8b00);
		rchk(`TSL_OFS_TR_BASE_HI, 32'h0);
		rchk(`TSL_OFS_TR_BASE_LO, 32'h2000);
		rchk(`TSL_OFS_TR_LIMIT, 32'h67);
		op(TSL_MODE_LEGACY, 64'h1000, 16'h0010, 32'h1);
		chk(st, 32'h8);
		op(TSL_MODE_LEGACY, 64'h1000, 16'h0014, 32'h1);
		chk(st, 32'h8);
		// Switch to a trapping task
		for (int i = 0; i < 26; i++) begin
			u_tsl_mem_model.mem[64'h2000 + 4 * i] = 32'h5a5a_0000 + i;
			blk[i] = (i == 25) ? {16'h0068, 16'($urandom) | 16'h0001} : $urandom;
			dyn[i] = $urandom;
			u_tsl_mem_model.mem[64'h3000 + 4 * i] = blk[i];
			bus(1'b1, `TSL_OFS_BLOCK + 12'(4 * i), dyn[i]);
		end
		// Closing byte of the permission map
		u_tsl_mem_model.mem[64'h2068] = 32'hff;
		u_tsl_mem_model.mem[64'h3068] = 32'hff;
		put_desc(64'h1018, 64'h3000, 20'h00067);
		op(TSL_MODE_LEGACY, 64'h1000, 16'h0018, 32'h2);
		chk(st, 32'h12);
		chk(64'(u_tsl_mem_model.n_rd - r0), 64'd28);
		chk(64'(u_tsl_mem_model.n_wr - w0), 64'd18);
		chk(u_tsl_mem_model.mem[64'h2068], 32'hff);
		for (int i = 0; i < 26; i++) begin
			chk(u_tsl_mem_model.mem[64'h2000 + 4 * i], isdyn(i) ? dyn[i] : 32'h5a5a_0000 + i);
			rchk(`TSL_OFS_BLOCK + 12'(4 * i), blk[i]);
		end
		rchk(`TSL_OFS_TR_SEL, 32'h18);
		put_desc(64'h1020, 64'h4000, 20'h00066);
		op(TSL_MODE_LEGACY, 64'h1000, 16'h0020, 32'h2);
		chk(st, 32'h4);
		op(TSL_MODE_LM64, 64'h1000, 16'h0020, 32'h2);
		chk(st, 32'h8);
		// 64-bit mode and compatibility mode loads with random bases
		for (int k = 0; k < 3; k++) begin
			b = {$urandom, $urandom & 32'hffff_fff0};
			put_desc(64'h1_0000_4008, b, 20'h00067);
			op(TSL_MODE_LM64, 64'h1_0000_4000, 16'h0008, 32'h1);
			chk(st, 32'h2);
			chk(64'(u_tsl_mem_model.n_rd - r0), 64'h4);
			chk(u_tsl_mem_model.mem[64'h1_0000_400c][9], 1'b1);
			rchk(`TSL_OFS_TR_BASE_HI, b[63:32]);
			rchk(`TSL_OFS_TR_BASE_LO, b[31:0]);
			put_desc(64'h6008, b, 20'h00067);
			op(TSL_MODE_COMPAT, 64'h6000, 16'h0008, 32'h1);
			chk(st, 32'h2);
			chk(64'(u_tsl_mem_model.n_rd - r0), 64'h2);
			rchk(`TSL_OFS_TR_BASE_HI, 32'h0);
		end
		print_verdict();
	end
endmodule
